// ===== verilog/pend_ctrl_map.vh
// Register offsets, field positions and reset values of the pending control block
// Assumes inclusion by bare name from the design file
`ifndef PEND_CTRL_MAP_VH
`define PEND_CTRL_MAP_VH

`define ICS_OFFSET        12'h004
`define ICS_SVC_SET_BIT   28
`define ICS_SVC_CLR_BIT   27
`define ICS_TICK_SET_BIT  26
`define ICS_TICK_CLR_BIT  25
`define PEND_RESET        1'b0
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ===== verilog/soft_exception_pending_ctrl.v
// Pending state of the service-call and tick exceptions, reached over AXI4-Lite
// Assumes a single 25 MHz clock, synchronous active-high reset, a compliant master
//
// Operation
// - Writing one to service set marks pending
// - Service set bit reads current pending state
// - Only software set makes service pending
// - Bit 27 write-one clears service pending
// - Bit 26 write-one sets tick pending
// - Tick set bit reads tick pending state
// - Separate write-only tick clear control bit
// - Service set control sits at bit 28
`timescale 1ns/1ps
`default_nettype none
`include "pend_ctrl_map.vh"

module soft_exception_pending_ctrl #(
    parameter ADDR_W = 12
) (
    input  wire              clk_sys,
    input  wire              srst,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg               svc_call_pend_q,
    output reg               tick_pend_q
);

////////////////////////////////////////////////////////////////////////////////
// Local constants
localparam [ADDR_W-1:0] ICS_ADDR   = `ICS_OFFSET;

// Write path states, one-hot
localparam [2:0]        WR_COLLECT = 3'h1;
localparam [2:0]        WR_APPLY   = 3'h2;
localparam [2:0]        WR_RESP    = 3'h4;

// Read path states, one-hot
localparam [2:0]        RD_IDLE    = 3'h1;
localparam [2:0]        RD_RESP    = 3'h2;
localparam [2:0]        RD_GAP     = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// Write path state and captured request
reg [2:0]        wr_state_q;
reg [2:0]        wr_state_d;
reg [ADDR_W-1:0] aw_q;
reg [ADDR_W-1:0] aw_d;
reg              aw_have_q;
reg              aw_have_d;
reg [31:0]       w_q;
reg [31:0]       w_d;
reg [3:0]        ws_q;
reg [3:0]        ws_d;
reg              w_have_q;
reg              w_have_d;
reg              awready_d;
reg              wready_d;
reg              bvalid_d;
reg [1:0]        bresp_d;

wire aw_take   = s_axi_awvalid & s_axi_awready;
wire w_take    = s_axi_wvalid & s_axi_wready;
wire do_write  = (wr_state_q == WR_APPLY);
wire hit_w     = (aw_q[ADDR_W-1:2] == ICS_ADDR[ADDR_W-1:2]);
wire lane3     = ws_q[3];
wire wr_effect = do_write & hit_w & lane3;

////////////////////////////////////////////////////////////////////////////////
// Write address capture
always @* begin
    aw_d      = aw_q;
    aw_have_d = aw_have_q;
    if (do_write) begin
        aw_have_d = 1'b0;
    end else if (aw_take) begin
        aw_d      = s_axi_awaddr;
        aw_have_d = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write data capture
always @* begin
    w_d      = w_q;
    ws_d     = ws_q;
    w_have_d = w_have_q;
    if (do_write) begin
        w_have_d = 1'b0;
    end else if (w_take) begin
        w_d      = s_axi_wdata;
        ws_d     = s_axi_wstrb;
        w_have_d = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write sequencing
always @* begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
        WR_COLLECT: begin
            if ((aw_have_q | aw_take) & (w_have_q | w_take)) begin
                wr_state_d = WR_APPLY;
            end
        end
        WR_APPLY: begin
            wr_state_d = WR_RESP;
        end
        WR_RESP: begin
            if (s_axi_bready) begin
                wr_state_d = WR_COLLECT;
            end
        end
        default: begin
            wr_state_d = WR_COLLECT;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Write handshake and response
always @* begin
    awready_d = (wr_state_q == WR_COLLECT) & ~aw_have_q & ~aw_take;
    wready_d  = (wr_state_q == WR_COLLECT) & ~w_have_q & ~w_take;
    bvalid_d  = (wr_state_d == WR_RESP);
    bresp_d   = s_axi_bresp;
    if (do_write) begin
        bresp_d = hit_w ? `RESP_OKAY : `RESP_SLVERR;
    end
end

always @(posedge clk_sys) begin
    if (srst) begin
        wr_state_q    <= WR_COLLECT;
        aw_q          <= {ADDR_W{1'b0}};
        aw_have_q     <= 1'b0;
        w_q           <= 32'h0000_0000;
        ws_q          <= 4'h0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
    end else begin
        wr_state_q    <= wr_state_d;
        aw_q          <= aw_d;
        aw_have_q     <= aw_have_d;
        w_q           <= w_d;
        ws_q          <= ws_d;
        w_have_q      <= w_have_d;
        s_axi_awready <= awready_d;
        s_axi_wready  <= wready_d;
        s_axi_bvalid  <= bvalid_d;
        s_axi_bresp   <= bresp_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pending state; a set beats a clear in the same write
wire svc_set  = wr_effect & w_q[`ICS_SVC_SET_BIT];
wire svc_clr  = wr_effect & w_q[`ICS_SVC_CLR_BIT];
wire tick_set = wr_effect & w_q[`ICS_TICK_SET_BIT];
wire tick_clr = wr_effect & w_q[`ICS_TICK_CLR_BIT];
wire svc_call_pend_d;
wire tick_pend_d;

pend_next_calc #(
    .SET_WINS (1)
) svc_call_next (
    .pend_q  (svc_call_pend_q),
    .set_req (svc_set),
    .clr_req (svc_clr),
    .pend_d  (svc_call_pend_d)
);

pend_next_calc #(
    .SET_WINS (1)
) tick_next (
    .pend_q  (tick_pend_q),
    .set_req (tick_set),
    .clr_req (tick_clr),
    .pend_d  (tick_pend_d)
);

always @(posedge clk_sys) begin
    if (srst) begin
        svc_call_pend_q <= `PEND_RESET;
        tick_pend_q     <= `PEND_RESET;
    end else begin
        svc_call_pend_q <= svc_call_pend_d;
        tick_pend_q     <= tick_pend_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read path state
reg [2:0]  rd_state_q;
reg [2:0]  rd_state_d;
reg        arready_d;
reg        rvalid_d;
reg [31:0] rdata_d;
reg [1:0]  rresp_d;
reg [31:0] ics_word;

wire ar_take = s_axi_arvalid & s_axi_arready;
wire hit_r   = (s_axi_araddr[ADDR_W-1:2] == ICS_ADDR[ADDR_W-1:2]);

////////////////////////////////////////////////////////////////////////////////
// Readable image of the register; clear controls read as zero
always @* begin
    ics_word                   = 32'h0000_0000;
    ics_word[`ICS_SVC_SET_BIT]  = svc_call_pend_q;
    ics_word[`ICS_TICK_SET_BIT] = tick_pend_q;
end

////////////////////////////////////////////////////////////////////////////////
// Read sequencing
always @* begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
        RD_IDLE: begin
            if (ar_take) begin
                rd_state_d = RD_RESP;
            end
        end
        RD_RESP: begin
            if (s_axi_rready) begin
                rd_state_d = RD_GAP;
            end
        end
        RD_GAP: begin
            rd_state_d = RD_IDLE;
        end
        default: begin
            rd_state_d = RD_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Read handshake and data
always @* begin
    arready_d = (rd_state_d == RD_IDLE);
    rvalid_d  = (rd_state_d == RD_RESP);
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (ar_take) begin
        rdata_d = hit_r ? ics_word : 32'h0000_0000;
        rresp_d = hit_r ? `RESP_OKAY : `RESP_SLVERR;
    end
end

always @(posedge clk_sys) begin
    if (srst) begin
        rd_state_q    <= RD_IDLE;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `RESP_OKAY;
    end else begin
        rd_state_q    <= rd_state_d;
        s_axi_arready <= arready_d;
        s_axi_rvalid  <= rvalid_d;
        s_axi_rdata   <= rdata_d;
        s_axi_rresp   <= rresp_d;
    end
end

endmodule // soft_exception_pending_ctrl

////////////////////////////////////////////////////////////////////////////////
// Next value of one pending flag
module pend_next_calc #(
    parameter SET_WINS = 1
) (
    input  wire pend_q,
    input  wire set_req,
    input  wire clr_req,
    output reg  pend_d
);

always @* begin
    pend_d = pend_q;
    if (SET_WINS != 0) begin
        if (set_req) begin
            pend_d = 1'b1;
        end else if (clr_req) begin
            pend_d = 1'b0;
        end
    end else begin
        if (clr_req) begin
            pend_d = 1'b0;
        end else if (set_req) begin
            pend_d = 1'b1;
        end
    end
end

endmodule // pend_next_calc

`default_nettype wire

// ===== verification/pend_ctrl_assertions.sv
// Checker of the pending control block
// Bound to the top ports, one clock
`timescale 1ns/1ps
`default_nettype none
module pend_chk (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        svc_call_pend_q,
    input wire logic        tick_pend_q,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_rdata
);
    reg        bv_q;
    reg [31:0] d_q;
    wire [1:0] p = {svc_call_pend_q, tick_pend_q};
    wire       wr = s_axi_bvalid && !bv_q && !s_axi_bresp;
    always @(posedge clk_sys) begin
        bv_q <= s_axi_bvalid;
        if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wstrb[3] ? s_axi_wdata : 32'h0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence rd_take; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h004; endsequence
    chk_svc_set: assert property (wr && d_q[28] |-> p[1]) else $error("svc set");
    chk_svc_clear: assert property (wr && d_q[28:27] == 1 |-> !p[1]) else $error("svc clr");
    chk_tick_set: assert property (wr && d_q[26] |-> p[0]) else $error("tick set");
    chk_tick_clear: assert property (wr && d_q[26:25] == 1 |-> !p[0]) else $error("tick clr");
    chk_pend_hold: assert property (!wr |-> $stable(p)) else $error("pend moved");
    chk_zero_keep: assert property (wr && d_q[28:25] == 0 |-> $stable(p)) else $error("zero");
    chk_read_state: assert property (rd_take |=> s_axi_rvalid && s_axi_rdata ==
        {3'h0, $past(p[1]), 1'h0, $past(p[0]), 26'h0}) else $error("read data");
    chk_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp)) else $error("bresp");
endmodule // pend_chk
bind soft_exception_pending_ctrl pend_chk chk (.*);
`default_nettype wire

// ===== verification/test_soft_exception_pending_ctrl.sv
// Bench of the pending control block
// Drives AXI4-Lite by hand
`timescale 1ns/1ps
`default_nettype none
module test_soft_exception_pending_ctrl;
    logic clk_sys = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, svc_call_pend_q, tick_pend_q;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int mismatches = 0, samples_checked = 0, n;
    soft_exception_pending_ctrl uut (.*);
    always #20 clk_sys = ~clk_sys;
    task summarize;
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input [31:0] s, e);
        samples_checked++;
        if (s !== e) mismatches++;
        if (s !== e) $display("CHECK FAILED %0t %h %h", $time, s, e);
    endtask
    // One write (w) or read, expected rdata in d
    task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        @(posedge clk_sys);
        n = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        do begin
            @(posedge clk_sys);
            if (++n > 50) mismatches++;
            if (n > 50) summarize;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        check(w ? s_axi_bresp : s_axi_rresp, r);
        if (!w) check(s_axi_rdata, d);
    endtask
    task set_clear_seq;
        xfer(1, 12'h004, 32'h1000_0000, 4'hf, 2'h0);
        check(svc_call_pend_q, 1);
        xfer(1, 12'h004, 32'h0400_0000, 4'hf, 2'h0);
        check(tick_pend_q, 1);
        xfer(0, 12'h004, 32'h1400_0000, 4'h0, 2'h0);
        xfer(1, 12'h004, 32'h0000_0000, 4'hf, 2'h0);
        check({svc_call_pend_q, tick_pend_q}, 3);
        xfer(1, 12'h004, 32'h0a00_0000, 4'hf, 2'h0);
        check({svc_call_pend_q, tick_pend_q}, 0);
        xfer(0, 12'h004, 32'h0000_0000, 4'h0, 2'h0);
    endtask
    task map_seq;
        xfer(1, 12'h008, 32'h1000_0000, 4'hf, 2'h2);
        xfer(1, 12'h004, 32'h1000_0000, 4'h7, 2'h0);
        xfer(0, 12'h008, 32'h0000_0000, 4'h0, 2'h2);
        check(svc_call_pend_q, 0);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 0;
        set_clear_seq;
        map_seq;
        summarize;
    end
endmodule // test_soft_exception_pending_ctrl
`default_nettype wire
